// ===== shared/rdf_pkg.sv
package rdf_pkg;

    // Field widths of the descriptor and host bus
    localparam int REF_W  = 14;
    localparam int CNT_W  = 16;
    localparam int STAT_W = 6;
    localparam int OFF_W  = 2;
    localparam int ADDR_W = 8;
    localparam int INT_W  = 2;
    localparam int PKT_W  = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PKTS  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h10;

    // Field positions
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_OFF_LSB = 1;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_ERR_BIT  = 1;
    localparam int STATE_REF_LSB = 8;

    // Reset values and fixed codes
    localparam logic              CTRL_EN_RST  = 1'h0;
    localparam logic [OFF_W-1:0]  CTRL_OFF_RST = 2'h0;
    localparam logic [INT_W-1:0]  IMASK_RST    = 2'h0;
    localparam logic [CNT_W-1:0]  SHORT_FCS    = 16'h8000;
    localparam logic [OFF_W-1:0]  OFF_NONE     = 2'h0;
    localparam logic [STAT_W-1:0] STAT_NONE    = 6'h00;

    typedef enum logic [4:0] {
        S_GET   = 5'b00001,
        S_FILL  = 5'b00010,
        S_LINK  = 5'b00100,
        S_CHAIN = 5'b01000,
        S_DESC  = 5'b10000
    } rdf_state_e;

    // Per-byte error flags from the frame processor
    typedef struct packed {
        logic short_fcs;
        logic abort;
        logic not_byte;
        logic crc;
        logic too_long;
        logic overrun;
    } rdf_err_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        rdf_err_s   err;
    } rdf_byte_s;

    // Free descriptor as read from host memory
    typedef struct packed {
        logic [REF_W-1:0] ref_id;
        logic [CNT_W-1:0] size;
    } rdf_free_s;

    // Data byte store into a buffer
    typedef struct packed {
        logic [REF_W-1:0] ref_id;
        logic [CNT_W-1:0] addr;
        logic [7:0]       data;
    } rdf_wr_s;

    // Device-written fields of a receive_packet_descriptor
    typedef struct packed {
        logic [REF_W-1:0]  ref_id;
        logic              chain_end;
        logic [OFF_W-1:0]  offset;
        logic [STAT_W-1:0] status;
        logic [CNT_W-1:0]  count;
        logic [REF_W-1:0]  next_ref;
    } rdf_desc_s;

endpackage

// ===== design/rdf_rx_desc.sv
// Contract
// RL1: Chain-end flag one in last or sole descriptor, zero in earlier ones.
// RL2: Offset counts undefined filler bytes before packet data in a buffer.
// RL3: Only first descriptor of a chain carries offset; others get zero.
// RL4: Status bit 0 overrun, bit 1 oversize, bit 2 CRC error.
// RL5: Status bit 3 non-whole bytes, bit 4 abort, bit 5 always zero.
// RL6: Status meaningful only in last or sole descriptor.
// RL7: Sixteen-bit byte count of bytes holding packet data per descriptor.
// RL8: Byte count excludes offset filler bytes.
// RL9: Count above 32767 flags packet shorter than its FCS.
// RL10: Host treats count invalid when overrun or abort set.
// RL11: With chain-end zero, next field holds reference of following descriptor.
// RL12: Host ignores next field when chain-end is one.
// RL13: Chain descriptors when a packet needs more than one buffer.
// RL14: Host programs buffer size as non-zero multiple of four up to 32764.
// RL15: Buffer size is used from every descriptor, mid-chain included.
// RL16: Device reads but never writes buffer size and start address.
// RL17: All other descriptor fields are written only by the device.
// RL18: Never overfill a buffer, filler included; move on when full.
// RL19: Status written only after the final packet byte is stored.
`timescale 1ns/1ps
module rdf_rx_desc
(
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [rdf_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    output logic                                irq,
    input  wire logic                           free_valid,
    input  wire rdf_pkg::rdf_free_s             free_desc,
    output logic                                free_ready,
    input  wire logic                           in_valid,
    input  wire rdf_pkg::rdf_byte_s             in_byte,
    output logic                                in_ready,
    output logic                                wr_valid,
    output rdf_pkg::rdf_wr_s                    wr_req,
    input  wire logic                           wr_ready,
    output logic                                dw_valid,
    output rdf_pkg::rdf_desc_s                  dw_desc,
    input  wire logic                           dw_ready
);

    typedef struct packed {
        rdf_pkg::rdf_state_e                st;
        logic [rdf_pkg::REF_W-1:0]          cur_ref;
        logic [rdf_pkg::CNT_W-1:0]          cur_size;
        logic [rdf_pkg::CNT_W-1:0]          pos;
        logic [rdf_pkg::CNT_W-1:0]          cnt;
        logic                               first;
        logic [rdf_pkg::OFF_W-1:0]          off;
        rdf_pkg::rdf_err_s                  err;
        logic                               last_seen;
        logic                               ctrl_en;
        logic [rdf_pkg::OFF_W-1:0]          ctrl_off;
        logic [rdf_pkg::INT_W-1:0]          istat;
        logic [rdf_pkg::INT_W-1:0]          imask;
        logic [rdf_pkg::PKT_W-1:0]          pkts;
        logic [31:0]                        prdata;
        logic                               pready;
        logic                               pslverr;
        logic                               irq;
        logic                               free_ready;
        logic                               in_ready;
        logic                               wr_valid;
        rdf_pkg::rdf_wr_s                   wr_req;
        logic                               dw_valid;
        rdf_pkg::rdf_desc_s                 dw_desc;
    } rdf_regs_s;

    rdf_regs_s                              s_reg;
    rdf_regs_s                              s_next;

    logic                                   setup;
    logic                                   wr_acc;
    logic                                   mapped;
    logic [rdf_pkg::INT_W-1:0]              ev;
    logic [rdf_pkg::INT_W-1:0]              w1c;
    logic [rdf_pkg::STAT_W-1:0]             fin_stat;

    // Bus phase decode
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && s_reg.pready && pwrite;
    assign mapped = (paddr == rdf_pkg::ADDR_CTRL) || (paddr == rdf_pkg::ADDR_ISTAT) ||
                    (paddr == rdf_pkg::ADDR_IMASK) || (paddr == rdf_pkg::ADDR_PKTS) ||
                    (paddr == rdf_pkg::ADDR_STATE);

    // Final status: errors gathered over the packet, top bit zero
    assign fin_stat = {1'b0, s_reg.err.abort, s_reg.err.not_byte,   // [RL5]
                       s_reg.err.crc, s_reg.err.too_long, s_reg.err.overrun};  // [RL4]

    // Next-state logic for engine, registers and outputs
    always_comb
    begin
        s_next = s_reg;
        ev = '0;
        w1c = '0;

        // Register writes take effect at the accepted access edge
        if (wr_acc && paddr == rdf_pkg::ADDR_CTRL)
        begin
            s_next.ctrl_en  = pwdata[rdf_pkg::CTRL_EN_BIT];
            s_next.ctrl_off = pwdata[rdf_pkg::CTRL_OFF_LSB +: rdf_pkg::OFF_W];
        end
        if (wr_acc && paddr == rdf_pkg::ADDR_IMASK)
        begin
            s_next.imask = pwdata[rdf_pkg::INT_W-1:0];
        end
        if (wr_acc && paddr == rdf_pkg::ADDR_ISTAT)
        begin
            w1c = pwdata[rdf_pkg::INT_W-1:0];
        end

        unique case (s_reg.st)
            rdf_pkg::S_GET:
            begin
                s_next.free_ready = s_reg.ctrl_en;
                if (free_valid && s_reg.free_ready)
                begin
                    s_next.free_ready = 1'b0;
                    s_next.cur_ref    = free_desc.ref_id;
                    s_next.cur_size   = free_desc.size;   // [RL15] [RL16]
                    s_next.off        = s_reg.ctrl_off;
                    s_next.pos        = {{(rdf_pkg::CNT_W-rdf_pkg::OFF_W){1'b0}}, s_reg.ctrl_off};  // [RL2]
                    s_next.cnt        = '0;
                    s_next.first      = 1'b1;
                    s_next.err        = '0;
                    s_next.last_seen  = 1'b0;
                    s_next.in_ready   = 1'b1;
                    s_next.st         = rdf_pkg::S_FILL;
                end
            end
            rdf_pkg::S_FILL:
            begin
                if (s_reg.wr_valid)
                begin
                    if (wr_ready)
                    begin
                        s_next.wr_valid = 1'b0;
                        if (s_reg.last_seen)
                        begin
                            // Status goes out only after the last byte is stored [RL19]
                            s_next.dw_valid          = 1'b1;
                            s_next.dw_desc.ref_id    = s_reg.cur_ref;
                            s_next.dw_desc.chain_end = 1'b1;                      // [RL1]
                            s_next.dw_desc.offset    = s_reg.first ? s_reg.off : rdf_pkg::OFF_NONE;  // [RL3]
                            s_next.dw_desc.status    = fin_stat;                  // [RL6]
                            s_next.dw_desc.count     = s_reg.err.short_fcs ?
                                                       (s_reg.cnt | rdf_pkg::SHORT_FCS) : s_reg.cnt;  // [RL9]
                            s_next.dw_desc.next_ref  = '0;                        // [RL17]
                            s_next.st                = rdf_pkg::S_DESC;
                        end
                        else if (s_reg.pos == s_reg.cur_size)
                        begin
                            // Buffer full: fetch another and chain [RL18] [RL13]
                            s_next.free_ready = 1'b1;
                            s_next.st         = rdf_pkg::S_LINK;
                        end
                        else
                        begin
                            s_next.in_ready = 1'b1;
                        end
                    end
                end
                else if (in_valid && s_reg.in_ready)
                begin
                    s_next.in_ready       = 1'b0;
                    s_next.wr_valid       = 1'b1;
                    s_next.wr_req.ref_id  = s_reg.cur_ref;
                    s_next.wr_req.addr    = s_reg.pos;
                    s_next.wr_req.data    = in_byte.data;
                    s_next.pos            = s_reg.pos + 16'h0001;
                    s_next.cnt            = s_reg.cnt + 16'h0001;  // [RL7] [RL8]
                    s_next.err            = s_reg.err | in_byte.err;
                    s_next.last_seen      = in_byte.last;
                end
            end
            rdf_pkg::S_LINK:
            begin
                if (free_valid && s_reg.free_ready)
                begin
                    // Close the full buffer with a link to the new one
                    s_next.free_ready        = 1'b0;
                    s_next.dw_valid          = 1'b1;
                    s_next.dw_desc.ref_id    = s_reg.cur_ref;
                    s_next.dw_desc.chain_end = 1'b0;                           // [RL1]
                    s_next.dw_desc.offset    = s_reg.first ? s_reg.off : rdf_pkg::OFF_NONE;  // [RL3]
                    s_next.dw_desc.status    = rdf_pkg::STAT_NONE;              // [RL6] [RL19]
                    s_next.dw_desc.count     = s_reg.cnt;                       // [RL7] [RL8]
                    s_next.dw_desc.next_ref  = free_desc.ref_id;                // [RL11]
                    s_next.cur_ref           = free_desc.ref_id;
                    s_next.cur_size          = free_desc.size;                  // [RL15]
                    s_next.pos               = '0;
                    s_next.cnt               = '0;
                    s_next.first             = 1'b0;
                    s_next.st                = rdf_pkg::S_CHAIN;
                end
            end
            rdf_pkg::S_CHAIN:
            begin
                if (dw_ready)
                begin
                    s_next.dw_valid = 1'b0;
                    s_next.in_ready = 1'b1;
                    s_next.st       = rdf_pkg::S_FILL;
                end
            end
            rdf_pkg::S_DESC:
            begin
                if (dw_ready)
                begin
                    s_next.dw_valid = 1'b0;
                    s_next.pkts     = s_reg.pkts + 16'h0001;
                    ev[rdf_pkg::INT_DONE_BIT] = 1'b1;
                    ev[rdf_pkg::INT_ERR_BIT]  = |s_reg.dw_desc.status;
                    s_next.free_ready = s_reg.ctrl_en;
                    s_next.st         = rdf_pkg::S_GET;
                end
            end
        endcase

        // Sticky events: a new event wins over a clear in the same cycle
        s_next.istat = (s_reg.istat & ~w1c) | ev;
        s_next.irq   = |(s_next.istat & s_next.imask);

        // Zero-wait answer: ready and read data loaded at the setup edge
        s_next.pready  = setup;
        s_next.pslverr = setup && !mapped;
        s_next.prdata  = '0;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                rdf_pkg::ADDR_CTRL:
                begin
                    s_next.prdata[rdf_pkg::CTRL_EN_BIT] = s_reg.ctrl_en;
                    s_next.prdata[rdf_pkg::CTRL_OFF_LSB +: rdf_pkg::OFF_W] = s_reg.ctrl_off;
                end
                rdf_pkg::ADDR_ISTAT: s_next.prdata[rdf_pkg::INT_W-1:0] = s_reg.istat;
                rdf_pkg::ADDR_IMASK: s_next.prdata[rdf_pkg::INT_W-1:0] = s_reg.imask;
                rdf_pkg::ADDR_PKTS:  s_next.prdata[rdf_pkg::PKT_W-1:0] = s_reg.pkts;
                rdf_pkg::ADDR_STATE:
                begin
                    s_next.prdata[4:0] = s_reg.st;
                    s_next.prdata[rdf_pkg::STATE_REF_LSB +: rdf_pkg::REF_W] = s_reg.cur_ref;
                end
                default: s_next.prdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg          <= '0;
            s_reg.st       <= rdf_pkg::S_GET;
            s_reg.ctrl_en  <= rdf_pkg::CTRL_EN_RST;
            s_reg.ctrl_off <= rdf_pkg::CTRL_OFF_RST;
            s_reg.imask    <= rdf_pkg::IMASK_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign prdata     = s_reg.prdata;
    assign pready     = s_reg.pready;
    assign pslverr    = s_reg.pslverr;
    assign irq        = s_reg.irq;
    assign free_ready = s_reg.free_ready;
    assign in_ready   = s_reg.in_ready;
    assign wr_valid   = s_reg.wr_valid;
    assign wr_req     = s_reg.wr_req;
    assign dw_valid   = s_reg.dw_valid;
    assign dw_desc    = s_reg.dw_desc;

endmodule

// ===== tb/rdf_rx_desc_props.sv
`timescale 1ns/1ps
module rdf_rx_desc_props
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready,
    input wire logic                 free_valid,
    input wire rdf_pkg::rdf_free_s   free_desc,
    input wire logic                 free_ready,
    input wire logic                 wr_valid,
    input wire rdf_pkg::rdf_wr_s     wr_req,
    input wire logic                 wr_ready,
    input wire logic                 dw_valid,
    input wire rdf_pkg::rdf_desc_s   dw_desc,
    input wire logic                 dw_ready
);
    logic [13:0] cur_ref;
    logic [15:0] cur_size;
    logic [15:0] wcnt;
    logic        first_d;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Current buffer, bytes stored in it, first-descriptor flag
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cur_ref  <= '0;
            cur_size <= '0;
            wcnt     <= '0;
            first_d  <= 1'b1;
        end
        else
        begin
            if (free_valid && free_ready)
                {cur_ref, cur_size} <= free_desc;
            if (dw_valid && dw_ready)
                wcnt <= '0;
            else if (wr_valid && wr_ready)
                wcnt <= wcnt + 16'h0001;
            if (dw_valid && dw_ready)
                first_d <= dw_desc.chain_end;
        end

    access_once_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("access cycle not answered exactly once");
    stat_bit5_a: assert property (dw_valid |-> !dw_desc.status[5])
        else $error("status bit 5 not zero");
    buf_bound_a: assert property (wr_valid |-> wr_req.addr < cur_size && wr_req.ref_id == cur_ref)
        else $error("store outside current buffer");
    store_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_req))
        else $error("store request dropped or changed");
    desc_hold_a: assert property (dw_valid && !dw_ready |=> dw_valid && $stable(dw_desc))
        else $error("descriptor write dropped or changed");
    link_next_a: assert property (dw_valid && !dw_desc.chain_end |-> dw_desc.next_ref == cur_ref)
        else $error("link does not name the next buffer");
    byte_count_a: assert property (dw_valid |-> dw_desc.count[14:0] == wcnt[14:0])
        else $error("byte count differs from bytes stored");
    later_off_a: assert property (dw_valid && !first_d |-> dw_desc.offset == rdf_pkg::OFF_NONE)
        else $error("offset nonzero after first descriptor");
    status_late_a: assert property (dw_valid |-> !wr_valid && (dw_desc.chain_end || dw_desc.status == 6'h00))
        else $error("status written too early");

    chain_c: cover property (dw_valid && dw_ready && !dw_desc.chain_end);
    short_c: cover property (dw_valid && dw_desc.count[15]);
    stall_c: cover property (wr_valid && !wr_ready);
endmodule

bind rdf_rx_desc rdf_rx_desc_props props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .free_valid(free_valid), .free_desc(free_desc), .free_ready(free_ready), .wr_valid(wr_valid),
    .wr_req(wr_req), .wr_ready(wr_ready), .dw_valid(dw_valid), .dw_desc(dw_desc), .dw_ready(dw_ready));

// ===== tb/rdf_host_mem.sv
`timescale 1ns/1ps
module rdf_host_mem
#(
    parameter int SZ = 8
)
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           slow,
    output logic                free_valid,
    output rdf_pkg::rdf_free_s  free_desc,
    input  wire logic           free_ready,
    output logic                wr_ready,
    output logic                dw_ready
);
    logic [13:0] nref;

    // Host supplies only reference and size; inverted pattern when idle
    assign free_desc = free_valid ? {nref, 16'(SZ)} : ~{nref, 16'(SZ)};

    // Buffers handed out in order; stores and writes stall when slow
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            nref       <= 14'h0001;
            free_valid <= 1'b0;
            wr_ready   <= 1'b0;
            dw_ready   <= 1'b0;
        end
        else
        begin
            free_valid <= 1'b1;
            if (free_valid && free_ready)
                nref <= nref + 14'h0001;
            wr_ready <= !slow || $urandom_range(1, 0) == 1;
            dw_ready <= !slow || $urandom_range(3, 0) == 0;
        end
endmodule

// ===== tb/rdf_rx_desc_tb.sv
`timescale 1ns/1ps
module rdf_rx_desc_tb;
    localparam int SZ  = 8;
    localparam int OFF = 3;
    logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, in_valid = 0;
    logic [7:0]          paddr = '0;
    logic [31:0]         pwdata = '0, prdata;
    logic                pready, pslverr, irq, free_valid, free_ready, in_ready, wr_valid, wr_ready, dw_valid, dw_ready;
    rdf_pkg::rdf_free_s  free_desc;
    rdf_pkg::rdf_byte_s  in_byte = '0;
    rdf_pkg::rdf_wr_s    wr_req;
    rdf_pkg::rdf_desc_s  dw_desc;
    rdf_pkg::rdf_desc_s  dq[$];
    rdf_pkg::rdf_wr_s    wq[$];
    logic [33:0]         aq[$];
    logic [13:0]         nref = 14'h0001;
    int                  failures = 0, check_count = 0, npkt = 0;

    always #50 pclk = ~pclk;

    rdf_rx_desc uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .free_valid(free_valid),
        .free_desc(free_desc), .free_ready(free_ready), .in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
        .wr_valid(wr_valid), .wr_req(wr_req), .wr_ready(wr_ready), .dw_valid(dw_valid), .dw_desc(dw_desc),
        .dw_ready(dw_ready));
    rdf_host_mem #(.SZ(SZ)) host (.pclk(pclk), .presetn(presetn), .slow(slow), .free_valid(free_valid),
        .free_desc(free_desc), .free_ready(free_ready), .wr_ready(wr_ready), .dw_ready(dw_ready));

    task automatic conclude();
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            failures++;
        end
    endtask

    // One APB transfer; expected answer noted first
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        aq.push_back({wr, err, err ? 32'h0 : d});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next call never re-drives psel in this step
        @(posedge pclk);
    endtask

    // Note expected descriptors, then stream the packet bytes
    task automatic send(input int len, input logic [5:0] err);
        rdf_pkg::rdf_desc_s e;
        logic [7:0] d;
        logic [7:0] bq[$];
        int pos, i;
        e = '0;
        e.ref_id = nref;
        e.offset = 2'(OFF);
        pos = OFF;
        for (i = 0; i < len; i++)
        begin
            if (pos == SZ)
            begin
                e.next_ref = nref + 14'h0001;
                dq.push_back(e);
                nref++;
                e = '0;
                e.ref_id = nref;
                pos = 0;
            end
            d = 8'($urandom);
            bq.push_back(d);
            wq.push_back({e.ref_id, 16'(pos), d});
            pos++;
            e.count++;
        end
        e.chain_end = 1'b1;
        e.status = {1'b0, err[4:0]};
        e.count[15] = err[5];
        dq.push_back(e);
        nref++;
        npkt++;
        for (i = 0; i < len; i++)
        begin
            in_valid <= 1'b1;
            in_byte  <= {bq[i], i == len - 1, (i == len - 1) ? err : 6'h00};
            do
            begin
                @(posedge pclk);
            end
            while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        while (dq.size() != 0)
        begin
            @(posedge pclk);
        end
    endtask

    // Completed APB access against oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
        begin
            logic [33:0] e;
            e = aq.pop_front();
            chk("pslverr", 64'(e[32]), 64'(pslverr));
            if (!e[33])
                chk("prdata", 64'(e[31:0]), 64'(prdata));
        end

    // Accepted descriptor against oldest note, host-ignored fields masked
    always @(posedge pclk)
        if (dw_valid === 1'b1 && dw_ready)
        begin
            rdf_pkg::rdf_desc_s e, m;
            e = dq.pop_front();
            m = '1;
            if (!e.chain_end)
                m.status = '0;
            else
                m.next_ref = '0;
            if (e.chain_end && (e.status[0] || e.status[4]))
                m.count = '0;
            chk("descriptor", 64'(e & m), 64'(dw_desc & m));
        end

    // Accepted byte store against oldest note: buffer, position, data
    always @(posedge pclk)
        if (wr_valid === 1'b1 && wr_ready)
        begin
            rdf_pkg::rdf_wr_s e;
            e = wq.pop_front();
            chk("store", 64'(e), 64'(wr_req));
        end

    initial
    begin
        void'($urandom(32'h9bf4a267));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, rdf_pkg::ADDR_CTRL, 32'h0, 1'b0);
        apb(1'b0, rdf_pkg::ADDR_IMASK, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 1'b1);
        apb(1'b1, 8'h20, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, rdf_pkg::ADDR_CTRL, 32'h7, 1'b0);
        for (int k = 0; k < 14; k++)
        begin
            int len;
            len = 1 + $urandom_range(19, 0);
            if ((len - 5) % 8 == 0)
                len++;
            slow <= (k >= 7);
            send(len, (k % 7 < 6) ? 6'h01 << (k % 7) : 6'h00);
        end
        apb(1'b0, rdf_pkg::ADDR_PKTS, 32'(npkt), 1'b0);
        apb(1'b0, rdf_pkg::ADDR_ISTAT, 32'h3, 1'b0);
        chk("irq", 64'h0, 64'(irq));
        apb(1'b1, rdf_pkg::ADDR_IMASK, 32'h2, 1'b0);
        repeat (2) @(posedge pclk);
        chk("irq", 64'h1, 64'(irq));
        apb(1'b1, rdf_pkg::ADDR_ISTAT, 32'h3, 1'b0);
        repeat (2) @(posedge pclk);
        chk("irq", 64'h0, 64'(irq));
        apb(1'b0, rdf_pkg::ADDR_ISTAT, 32'h0, 1'b0);
        apb(1'b0, rdf_pkg::ADDR_STATE, 32'({nref, 3'h0, rdf_pkg::S_FILL}), 1'b0);
        conclude();
    end

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge pclk);
        failures++;
        conclude();
    end
endmodule
